// ==== verilog/tmrfl_top.sv ====
`timescale 1ns/1ps
`include "tmrfl_defs.svh"
module tmrfl_top
   import tmrfl_pkg::*;
#(
   parameter int NCH = 8,
   parameter int AW = 12
) (
   // clock, reset, enable
   input wire logic CORE_CLK_I,
   input wire logic RST_B_I,
   input wire logic CE_I,
   // apb slave
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [AW-1:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   // channel events and fault pin
   input wire logic [NCH-1:0] CH_EVT_I,
   input wire logic FAULT_PIN_I,
   // controls to the timer
   output logic [NCH-1:0] CH_FLAG_O,
   output logic [7:0] FEATURE_MODE_O,
   output logic [7:0] FAULT_CH_EN_O,
   output logic FAULT_AUTO_CLR_O,
   // interrupt
   output logic IRQ_O
);
   ////////////////////////////////////////////////////////////////////////////////
   // bus decode
   logic pready_r; // access phase answered
   logic pslverr_r;
   logic [31:0] prdata_r;
   wire ask = PSEL_I & PENABLE_I & ~pready_r; // first access cycle
   wire take = PSEL_I & PENABLE_I & pready_r; // transfer completes here
   wire hit_mir = (PADDR_I == `TMRFL_ADDR_MIRROR);
   wire hit_mode = (PADDR_I == `TMRFL_ADDR_MODE);
   wire hit_sts = (PADDR_I == `TMRFL_ADDR_IRQ_STS);
   wire hit_msk = (PADDR_I == `TMRFL_ADDR_IRQ_MSK);
   wire hit_prot = (PADDR_I == `TMRFL_ADDR_PROTECT);
   wire mapped = hit_mir | hit_mode | hit_sts | hit_msk | hit_prot;
   wire wr_take = take & PWRITE_I & mapped;
   wire rd_take = take & ~PWRITE_I & mapped;

   ////////////////////////////////////////////////////////////////////////////////
   // state
   tmrfl_byte_t mode_r; // feature_mode_control
   tmrfl_byte_t mode_nxt;
   logic arm_seen_r; // arm bit was read as one
   logic arm_seen_nxt;
   logic [`TMRFL_IRQ_W-1:0] sts_r; // sticky interrupt status
   logic [`TMRFL_IRQ_W-1:0] sts_nxt;
   logic [`TMRFL_IRQ_W-1:0] msk_r; // interrupt mask
   logic [`TMRFL_IRQ_W-1:0] sts_set;
   logic fault_s1_r; // pin synchroniser, first stage
   logic fault_s2_r; // synchronised fault level
   logic irq_r;
   logic [31:0] rd_mux;

   tmrfl_flag_if flg ();

   ////////////////////////////////////////////////////////////////////////////////
   // flag mirror
   assign flg.rd = rd_take & hit_mir;
   assign flg.wr = wr_take & hit_mir;
   assign flg.wdata = PWDATA_I[7:0];

   tmrfl_flags #(
      .NCH(NCH)
   ) u_flags (
      .clk_i(CORE_CLK_I),
      .rst_b_i(RST_B_I),
      .ce_i(CE_I),
      .evt_i(CH_EVT_I),
      .flg(flg.owner)
   );

   // software is expected to use the mirror only with enhanced features on,
   // pairs linked and centre alignment off; nothing here enforces that
   assign CH_FLAG_O = flg.flags;

   ////////////////////////////////////////////////////////////////////////////////
   // fault decode shared by all channels
   tmrfl_fault u_fault (
      .clk_i(CORE_CLK_I),
      .rst_b_i(RST_B_I),
      .ce_i(CE_I),
      .fcm_i(mode_r[`TMRFL_MODE_FCM_HI:`TMRFL_MODE_FCM_LO]),
      .ch_en_o(FAULT_CH_EN_O),
      .auto_clr_o(FAULT_AUTO_CLR_O)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // mode register write; protected fields need write_protect_disable
   wire write_protect_disable = mode_r[`TMRFL_MODE_WRITE_PROTECT_DISABLE];
   wire mode_wr = wr_take & hit_mode;
   wire prot_wr = wr_take & hit_prot;
   wire arm_wr = prot_wr & PWDATA_I[`TMRFL_PROT_ARM]; // arm sets protection
   wire prot_ok = mode_wr & write_protect_disable;
   wire dis_set = mode_wr & PWDATA_I[`TMRFL_MODE_WRITE_PROTECT_DISABLE] & arm_seen_r;

   always_comb begin
      mode_nxt = mode_r;
      if (mode_wr) begin
         mode_nxt[`TMRFL_MODE_FIRQ] = PWDATA_I[`TMRFL_MODE_FIRQ];
         mode_nxt[`TMRFL_MODE_SYNC] = PWDATA_I[`TMRFL_MODE_SYNC];
      end
      if (prot_ok) begin
         // fault mode, capture check, enhanced enable
         mode_nxt[`TMRFL_MODE_FCM_HI] = PWDATA_I[`TMRFL_MODE_FCM_HI];
         mode_nxt[`TMRFL_MODE_FCM_LO] = PWDATA_I[`TMRFL_MODE_FCM_LO];
         mode_nxt[`TMRFL_MODE_CAPCHK] = PWDATA_I[`TMRFL_MODE_CAPCHK];
         mode_nxt[`TMRFL_MODE_ENH] = PWDATA_I[`TMRFL_MODE_ENH];
      end
      // zero written to the disable bit has no effect
      if (arm_wr) begin
         mode_nxt[`TMRFL_MODE_WRITE_PROTECT_DISABLE] = 1'b0;
      end else if (dis_set) begin
         mode_nxt[`TMRFL_MODE_WRITE_PROTECT_DISABLE] = 1'b1;
      end
      // output init is a strobe handled elsewhere; never stored
      mode_nxt[`TMRFL_MODE_INIT] = 1'b0;
   end

   // arm read seen while protected; dropped once used or re-armed
   assign arm_seen_nxt = (rd_take & hit_prot & ~write_protect_disable) ? 1'b1 :
                         (mode_wr | arm_wr) ? 1'b0 : arm_seen_r;

   ////////////////////////////////////////////////////////////////////////////////
   // interrupt sources; hardware set wins over write-one-to-clear
   wire fault_on = (mode_r[`TMRFL_MODE_FCM_HI:`TMRFL_MODE_FCM_LO] != 2'h0);
   assign sts_set[`TMRFL_IRQ_CHAN] = |CH_EVT_I;
   assign sts_set[`TMRFL_IRQ_FAULT] = fault_s2_r & fault_on &
                                      mode_r[`TMRFL_MODE_FIRQ];
   wire [`TMRFL_IRQ_W-1:0] sts_clr = (wr_take & hit_sts) ?
                                     PWDATA_I[`TMRFL_IRQ_W-1:0] : '0;
   assign sts_nxt = (sts_r & ~sts_clr) | sts_set;
   // level before its output flop; same cycle as status and mask, IRQ_O one cycle later
   wire irq_nxt = |(sts_r & msk_r);

   ////////////////////////////////////////////////////////////////////////////////
   // read data select; unused bits read zero
   always_comb begin
      rd_mux = 32'h00000000;
      if (hit_mir) begin
         rd_mux[NCH-1:0] = flg.flags;
      end else if (hit_mode) begin
         rd_mux[7:0] = mode_r;
      end else if (hit_sts) begin
         rd_mux[`TMRFL_IRQ_W-1:0] = sts_r;
      end else if (hit_msk) begin
         rd_mux[`TMRFL_IRQ_W-1:0] = msk_r;
      end else if (hit_prot) begin
         rd_mux[`TMRFL_PROT_ARM] = ~write_protect_disable; // arm is negated disable
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // apb answer: one wait state so read data come from a flop
   always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h00000000;
      end else if (CE_I) begin
         pready_r <= ask;
         pslverr_r <= ask & ~mapped;
         if (ask) begin
            prdata_r <= rd_mux;
         end
      end
   end

   // control registers
   always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         mode_r <= `TMRFL_MODE_RST;
         arm_seen_r <= 1'b0;
         sts_r <= '0;
         msk_r <= '0;
      end else if (CE_I) begin
         mode_r <= mode_nxt;
         arm_seen_r <= arm_seen_nxt;
         sts_r <= sts_nxt;
         if (wr_take & hit_msk) begin
            msk_r <= PWDATA_I[`TMRFL_IRQ_W-1:0];
         end
      end
   end

   // fault pin synchroniser and interrupt output
   always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         fault_s1_r <= 1'b0;
         fault_s2_r <= 1'b0;
         irq_r <= 1'b0;
      end else if (CE_I) begin
         fault_s1_r <= FAULT_PIN_I;
         fault_s2_r <= fault_s1_r;
         irq_r <= irq_nxt;
      end
   end

   assign PRDATA_O = prdata_r;
   assign PREADY_O = pready_r;
   assign PSLVERR_O = pslverr_r;
   assign FEATURE_MODE_O = mode_r;
   assign IRQ_O = irq_r;

   ////////////////////////////////////////////////////////////////////////////////
   chk_mirror_read_data:
   assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
      CE_I && ask && hit_mir |=> PRDATA_O == {24'h000000, $past(flg.flags)})
      else $error("mirror read data wrong");
   chk_protect_holds_fcm:
   assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
      CE_I && mode_wr && !write_protect_disable |=> $stable(mode_r[6:5]) && $stable(mode_r[0]))
      else $error("protected field written while protected");
   chk_arm_clears_dis:
   assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
      CE_I && arm_wr |=> !mode_r[`TMRFL_MODE_WRITE_PROTECT_DISABLE])
      else $error("arm write did not clear disable");
   chk_dis_needs_arm:
   assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
      CE_I && !write_protect_disable && !arm_seen_r |=> !mode_r[`TMRFL_MODE_WRITE_PROTECT_DISABLE])
      else $error("disable set without armed read");
   chk_fault_irq_set:
   assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
      CE_I && fault_s2_r && fault_on && mode_r[7] |=> sts_r[`TMRFL_IRQ_FAULT])
      else $error("fault did not raise status");
   chk_irq_follows_mask:
   assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
      CE_I |=> IRQ_O == $past(irq_nxt))
      else $error("interrupt output mismatch");
   chk_apb_one_wait:
   assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
      CE_I && ask |=> PREADY_O && (PSLVERR_O == !$past(mapped)))
      else $error("apb answer late or wrong");

   ////////////////////////////////////////////////////////////////////////////////
   // bus answer stands one cycle; read data only move at the latch edge,
   // so a slow master may sample late without seeing a torn word
   chk_ready_one_cycle:
   assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
      CE_I && PREADY_O |=> !PREADY_O)
      else $error("ready stood longer than one cycle");
   chk_rdata_holds:
   assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
      CE_I && !ask |=> $stable(PRDATA_O))
      else $error("read data moved outside an access");

   // protection: open writes land, a zero to the disable bit is ignored,
   // and an armed read followed by a one reopens the protected fields
   chk_fcm_write_open:
   assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
      CE_I && prot_ok |=> mode_r[`TMRFL_MODE_FCM_HI:`TMRFL_MODE_FCM_LO] ==
      $past(PWDATA_I[`TMRFL_MODE_FCM_HI:`TMRFL_MODE_FCM_LO]))
      else $error("fault mode not written while unprotected");
   chk_dis_set_armed:
   assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
      CE_I && dis_set |=> mode_r[`TMRFL_MODE_WRITE_PROTECT_DISABLE])
      else $error("armed disable write did not unlock");
   chk_dis_zero_noop:
   assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
      CE_I && mode_wr && write_protect_disable && !PWDATA_I[`TMRFL_MODE_WRITE_PROTECT_DISABLE]
      |=> mode_r[`TMRFL_MODE_WRITE_PROTECT_DISABLE])
      else $error("zero write cleared the disable bit");

   // interrupt status: events always set their bit, and the fault bit
   // stays quiet unless fault control and its enable are both on
   chk_chan_sts_set:
   assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
      CE_I && (|CH_EVT_I) |=> sts_r[`TMRFL_IRQ_CHAN])
      else $error("channel event did not set status");
   chk_fault_gated_off:
   assert property (@(posedge CORE_CLK_I) disable iff (!RST_B_I)
      CE_I && !(fault_on && mode_r[`TMRFL_MODE_FIRQ]) && !sts_r[`TMRFL_IRQ_FAULT]
      |=> !sts_r[`TMRFL_IRQ_FAULT])
      else $error("fault status set while disabled");
endmodule : tmrfl_top

// ==== verilog/tmrfl_defs.svh ====
`ifndef TMRFL_DEFS_SVH
`define TMRFL_DEFS_SVH

// register indices; byte address is four times the index
`define TMRFL_IDX_MIRROR 10'h019
`define TMRFL_IDX_MODE 10'h01A
`define TMRFL_IDX_IRQ_STS 10'h01B
`define TMRFL_IDX_IRQ_MSK 10'h01C
`define TMRFL_IDX_PROTECT 10'h01D

// byte addresses on the apb bus
`define TMRFL_ADDR_MIRROR {`TMRFL_IDX_MIRROR, 2'b00}
`define TMRFL_ADDR_MODE {`TMRFL_IDX_MODE, 2'b00}
`define TMRFL_ADDR_IRQ_STS {`TMRFL_IDX_IRQ_STS, 2'b00}
`define TMRFL_ADDR_IRQ_MSK {`TMRFL_IDX_IRQ_MSK, 2'b00}
`define TMRFL_ADDR_PROTECT {`TMRFL_IDX_PROTECT, 2'b00}

// feature mode register fields
`define TMRFL_MODE_FIRQ 7
`define TMRFL_MODE_FCM_HI 6
`define TMRFL_MODE_FCM_LO 5
`define TMRFL_MODE_CAPCHK 4
`define TMRFL_MODE_SYNC 3
`define TMRFL_MODE_WRITE_PROTECT_DISABLE 2
`define TMRFL_MODE_INIT 1
`define TMRFL_MODE_ENH 0
`define TMRFL_MODE_RST 8'h04

// protect register: write_protect_arm bit
`define TMRFL_PROT_ARM 0

// interrupt status bits
`define TMRFL_IRQ_CHAN 0
`define TMRFL_IRQ_FAULT 1
`define TMRFL_IRQ_W 2

// reset values and channel enable pattern
`define TMRFL_FLAG_RST 8'h00
`define TMRFL_EVEN_CH 8'h55
`define TMRFL_ALL_CH 8'hFF
`define TMRFL_NO_CH 8'h00

`endif

// ==== verilog/tmrfl_pkg.sv ====
package tmrfl_pkg;
   // fault control mode encoding
   typedef enum logic [1:0] {
      TMRFL_FC_OFF = 2'h0,
      TMRFL_FC_EVEN_MAN = 2'h1,
      TMRFL_FC_ALL_MAN = 2'h2,
      TMRFL_FC_ALL_AUTO = 2'h3
   } tmrfl_fault_e;
   typedef logic [7:0] tmrfl_byte_t;
endpackage : tmrfl_pkg

// ==== verilog/tmrfl_flag_if.sv ====
`timescale 1ns/1ps
// register-side access to the channel flag mirror
interface tmrfl_flag_if;
   logic rd; // one-cycle: mirror read taken
   logic wr; // one-cycle: mirror write taken
   logic [7:0] wdata; // write data low byte
   logic [7:0] flags; // current channel flags
   modport owner (input rd, input wr, input wdata, output flags);
   modport user (output rd, output wr, output wdata, input flags);
endinterface : tmrfl_flag_if

// ==== verilog/tmrfl_flags.sv ====
`timescale 1ns/1ps
`include "tmrfl_defs.svh"
module tmrfl_flags
   import tmrfl_pkg::*;
#(
   parameter int NCH = 8
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   // channel events
   input wire logic [NCH-1:0] evt_i,
   // register access
   tmrfl_flag_if.owner flg
);
   logic [NCH-1:0] flag_r; // channel_event_flag per channel
   logic [NCH-1:0] flag_nxt;
   logic [NCH-1:0] qual_r; // flag was seen set by a mirror read
   logic [NCH-1:0] qual_nxt;
   logic [NCH-1:0] clr; // bits a write may clear

   ////////////////////////////////////////////////////////////////////////////////
   // a zero clears only a qualified bit; a one is ignored
   assign clr = (flg.wr) ? (qual_r & ~flg.wdata[NCH-1:0]) : '0;
   // the event wins over a clear in the same cycle
   assign flag_nxt = (flag_r & ~clr) | evt_i;
   // a new event revokes a pending read; any write consumes it
   assign qual_nxt = (flg.wr) ? '0 :
                     (flg.rd) ? (flag_r & ~evt_i) :
                     (qual_r & ~evt_i);
   assign flg.flags = flag_r;

   // flag and qualification state
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         flag_r <= '0;
         qual_r <= '0;
      end else if (ce_i) begin
         flag_r <= flag_nxt;
         qual_r <= qual_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   chk_evt_sets_flag:
   assert property (@(posedge clk_i) disable iff (!rst_b_i)
      ce_i && (|evt_i) |=> ((flag_r & $past(evt_i)) == $past(evt_i)))
      else $error("event did not set its flag");
   chk_clear_needs_read:
   assert property (@(posedge clk_i) disable iff (!rst_b_i)
      ce_i |=> (($past(flag_r) & ~flag_r & ~$past(qual_r)) == '0))
      else $error("flag cleared without a qualifying read");
   chk_one_keeps_flag:
   assert property (@(posedge clk_i) disable iff (!rst_b_i)
      ce_i && flg.wr |=> (((flag_r ^ $past(flag_r)) & $past(flg.wdata[NCH-1:0]) &
      ~$past(evt_i)) == '0))
      else $error("writing one changed a flag");
   chk_zero_write_clears:
   assert property (@(posedge clk_i) disable iff (!rst_b_i)
      ce_i && flg.wr && flg.wdata == 8'h00 && evt_i == '0
      |=> flag_r == ($past(flag_r) & ~$past(qual_r)))
      else $error("zero write did not clear read flags");
   chk_evt_drops_qual:
   assert property (@(posedge clk_i) disable iff (!rst_b_i)
      ce_i && (|evt_i) |=> ((qual_r & $past(evt_i)) == '0))
      else $error("new event left flag clearable");
endmodule : tmrfl_flags

// ==== verilog/tmrfl_fault.sv ====
`timescale 1ns/1ps
`include "tmrfl_defs.svh"
module tmrfl_fault
   import tmrfl_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   // mode field
   input wire logic [1:0] fcm_i,
   // decoded controls
   output logic [7:0] ch_en_o,
   output logic auto_clr_o
);
   tmrfl_fault_e mode; // typed view of the field
   logic [7:0] en_nxt;

   ////////////////////////////////////////////////////////////////////////////////
   assign mode = tmrfl_fault_e'(fcm_i);

   // one field drives every channel together
   always_comb begin
      case (mode)
         TMRFL_FC_OFF: en_nxt = `TMRFL_NO_CH;
         TMRFL_FC_EVEN_MAN: en_nxt = `TMRFL_EVEN_CH;
         TMRFL_FC_ALL_MAN: en_nxt = `TMRFL_ALL_CH;
         TMRFL_FC_ALL_AUTO: en_nxt = `TMRFL_ALL_CH;
         default: en_nxt = `TMRFL_NO_CH;
      endcase
   end

   // registered decode
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ch_en_o <= `TMRFL_NO_CH;
         auto_clr_o <= 1'b0;
      end else if (ce_i) begin
         ch_en_o <= en_nxt;
         auto_clr_o <= (mode == TMRFL_FC_ALL_AUTO);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   chk_even_only_map:
   assert property (@(posedge clk_i) disable iff (!rst_b_i)
      ce_i && fcm_i == 2'h1 |=> ch_en_o == `TMRFL_EVEN_CH && !auto_clr_o)
      else $error("even-only fault mode decoded wrong");
endmodule : tmrfl_fault

// ==== testbench/timer_channel_flags_fault_mode_test.sv ====
`timescale 1ns/1ps
`include "tmrfl_defs.svh"
module timer_channel_flags_fault_mode_test;
   import tmrfl_pkg::*;
   // bench signals, all driven right after a rising edge
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [7:0] evt = 8'h00;
   logic fault_pin = 1'b0;
   // design outputs
   wire logic [31:0] prdata;
   wire logic pready;
   wire logic pslverr;
   wire logic [7:0] ch_flag;
   wire logic [7:0] mode;
   wire logic [7:0] fault_en;
   wire logic auto_clr;
   wire logic irq;
   int errors = 0; // mismatch count
   int n_tests = 0; // comparison count
   logic [31:0] rd; // scratch read data
   logic er; // scratch error flag

   ////////////////////////////////////////////////////////////////////////////
   // clock enable is tied high: stalls are not exercised here
   tmrfl_top dut_u (
      .CORE_CLK_I(clk), .RST_B_I(rst_b), .CE_I(1'b1),
      .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
      .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
      .PREADY_O(pready), .PSLVERR_O(pslverr),
      .CH_EVT_I(evt), .FAULT_PIN_I(fault_pin),
      .CH_FLAG_O(ch_flag), .FEATURE_MODE_O(mode),
      .FAULT_CH_EN_O(fault_en), .FAULT_AUTO_CLR_O(auto_clr), .IRQ_O(irq)
   );

   ////////////////////////////////////////////////////////////////////////////
   // 100 ns clock
   initial begin
      forever #50 clk = ~clk;
   end

   // compare and count
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // one apb transfer; holds everything until pready is sampled high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rdat, output logic err);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      // sample before this edge's updates land
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         errors++;
         $display("ERROR apb wait expected pready seen none");
      end
      rdat = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // read one register and compare
   task automatic rdchk(input string name, input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] d;
      logic e;
      apb(1'b0, a, 32'h0, d, e);
      check(name, d, exp);
   endtask : rdchk

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] x;
      logic e;
      apb(1'b1, a, d, x, e);
   endtask : wr

   // one-cycle event pulse; returns once the flag is visible
   task automatic pulse(input logic [7:0] m);
      @(posedge clk);
      evt <= m;
      @(posedge clk);
      evt <= 8'h00;
      @(posedge clk);
   endtask : pulse

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      rdchk("mirror", `TMRFL_ADDR_MIRROR, 32'h0000_0000);
      rdchk("mode", `TMRFL_ADDR_MODE, 32'h0000_0004);
      rdchk("irq_sts", `TMRFL_ADDR_IRQ_STS, 32'h0000_0000);
      rdchk("irq_msk", `TMRFL_ADDR_IRQ_MSK, 32'h0000_0000);
      rdchk("protect", `TMRFL_ADDR_PROTECT, 32'h0000_0000);
      apb(1'b0, 12'h000, 32'h0, rd, er);
      check("unmapped err", {31'h0, er}, 32'h0000_0001);
      check("unmapped data", rd, 32'h0000_0000);
      $display("test reset done");
   endtask : t_reset

   // set, mirror, and the read-then-write-zero clearing handshake
   task automatic t_flags();
      // mirror used with mode still at reset 0x04, so enhanced features are off
      pulse(8'hA5);
      check("ch_flag", {24'h0, ch_flag}, 32'h0000_00A5);
      rdchk("mirror set", `TMRFL_ADDR_MIRROR, 32'h0000_00A5);
      wr(`TMRFL_ADDR_MIRROR, 32'h0000_00FF);
      // marks were consumed by the ones write, so zeros now do nothing
      wr(`TMRFL_ADDR_MIRROR, 32'h0000_0000);
      @(posedge clk);
      check("no read no clear", {24'h0, ch_flag}, 32'h0000_00A5);
      rdchk("ones kept", `TMRFL_ADDR_MIRROR, 32'h0000_00A5);
      rdchk("mirror", `TMRFL_ADDR_MIRROR, 32'h0000_00A5);
      wr(`TMRFL_ADDR_MIRROR, 32'h0000_000F);
      rdchk("partial clear", `TMRFL_ADDR_MIRROR, 32'h0000_0005);
      pulse(8'h01);
      pulse(8'h80);
      wr(`TMRFL_ADDR_MIRROR, 32'h0000_0000);
      rdchk("late event kept", `TMRFL_ADDR_MIRROR, 32'h0000_0081);
      wr(`TMRFL_ADDR_MIRROR, 32'h0000_0000);
      @(posedge clk);
      check("full clear", {24'h0, ch_flag}, 32'h0000_0000);
      $display("test flags done");
   endtask : t_flags

   // event lands on the very edge of the clearing write
   task automatic t_collide();
      pulse(8'h10);
      rdchk("mirror", `TMRFL_ADDR_MIRROR, 32'h0000_0010);
      fork
         wr(`TMRFL_ADDR_MIRROR, 32'h0000_0000);
         begin
            repeat (3) @(posedge clk);
            evt <= 8'h10;
            @(posedge clk);
            evt <= 8'h00;
         end
      join
      @(posedge clk);
      check("set wins", {24'h0, ch_flag}, 32'h0000_0010);
      rdchk("mirror", `TMRFL_ADDR_MIRROR, 32'h0000_0010);
      wr(`TMRFL_ADDR_MIRROR, 32'h0000_0000);
      $display("test collide done");
   endtask : t_collide

   // every fault mode code, then write protection
   task automatic t_mode();
      logic [7:0] en_tab [4];
      en_tab = '{8'h00, 8'h55, 8'hFF, 8'hFF};
      for (int c = 0; c < 4; c++) begin
         wr(`TMRFL_ADDR_MODE, 32'(c) << 5 | 32'h4);
         repeat (2) @(posedge clk);
         check("mode out", {24'h0, mode}, 32'(c) << 5 | 32'h4);
         check("fault_en", {24'h0, fault_en}, {24'h0, en_tab[c]});
         check("auto_clr", {31'h0, auto_clr}, {31'h0, c == 3});
      end
      wr(`TMRFL_ADDR_PROTECT, 32'h0000_0001);
      rdchk("armed", `TMRFL_ADDR_MODE, 32'h0000_0060);
      wr(`TMRFL_ADDR_MODE, 32'h0000_0020);
      rdchk("locked", `TMRFL_ADDR_MODE, 32'h0000_0060);
      wr(`TMRFL_ADDR_MODE, 32'h0000_0064);
      rdchk("no armed read", `TMRFL_ADDR_MODE, 32'h0000_0060);
      rdchk("protect", `TMRFL_ADDR_PROTECT, 32'h0000_0001);
      wr(`TMRFL_ADDR_MODE, 32'h0000_0064);
      rdchk("unlocked", `TMRFL_ADDR_MODE, 32'h0000_0064);
      // zero to the disable bit and one to init both leave no trace
      wr(`TMRFL_ADDR_MODE, 32'h0000_0002);
      rdchk("zero no effect", `TMRFL_ADDR_MODE, 32'h0000_0004);
      $display("test mode done");
   endtask : t_mode

   // sticky status, mask, level output; fault gated by its enable
   task automatic t_irq();
      wr(`TMRFL_ADDR_IRQ_STS, 32'h0000_0003);
      wr(`TMRFL_ADDR_IRQ_MSK, 32'h0000_0003);
      pulse(8'h02);
      repeat (2) @(posedge clk);
      check("irq event", {31'h0, irq}, 32'h0000_0001);
      rdchk("sts", `TMRFL_ADDR_IRQ_STS, 32'h0000_0001);
      wr(`TMRFL_ADDR_IRQ_MSK, 32'h0000_0000);
      repeat (2) @(posedge clk);
      check("irq masked", {31'h0, irq}, 32'h0000_0000);
      wr(`TMRFL_ADDR_IRQ_MSK, 32'h0000_0003);
      wr(`TMRFL_ADDR_IRQ_STS, 32'h0000_0001);
      repeat (2) @(posedge clk);
      check("irq cleared", {31'h0, irq}, 32'h0000_0000);
      wr(`TMRFL_ADDR_MODE, 32'h0000_0044);
      fault_pin <= 1'b1;
      repeat (8) @(posedge clk);
      fault_pin <= 1'b0;
      repeat (6) @(posedge clk);
      rdchk("fault off", `TMRFL_ADDR_IRQ_STS, 32'h0000_0000);
      wr(`TMRFL_ADDR_MODE, 32'h0000_00C4);
      fault_pin <= 1'b1;
      repeat (8) @(posedge clk);
      fault_pin <= 1'b0;
      repeat (6) @(posedge clk);
      rdchk("fault on", `TMRFL_ADDR_IRQ_STS, 32'h0000_0002);
      check("irq fault", {31'h0, irq}, 32'h0000_0001);
      wr(`TMRFL_ADDR_IRQ_STS, 32'h0000_0002);
      rdchk("sts clear", `TMRFL_ADDR_IRQ_STS, 32'h0000_0000);
      $display("test irq done");
   endtask : t_irq

   ////////////////////////////////////////////////////////////////////////////
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : print_verdict

   // main sequence: reset held 16 cycles
   initial begin
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      t_reset();
      t_flags();
      t_collide();
      t_mode();
      t_irq();
      print_verdict();
   end

   // watchdog at 20000 cycles: the run needs well under that
   initial begin
      #2000000;
      errors++;
      $display("ERROR watchdog expected finish seen hang");
      print_verdict();
   end
endmodule : timer_channel_flags_fault_mode_test
